//--- hw/sspc_top.sv
// serial port control: frame format, word size, slave output disable
// assumes an axi4-lite master and an external serial master on the link
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "sspc_consts.svh"
module sspc_top
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // axi4-lite write address and data
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [11:0] awaddr_i,
   input wire logic wvalid_i,
   output logic wready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   // axi4-lite write response
   output logic bvalid_o,
   input wire logic bready_i,
   output sspc_pkg::sspc_resp_type bresp_o,
   // axi4-lite read
   input wire logic arvalid_i,
   output logic arready_o,
   input wire logic [11:0] araddr_i,
   output logic rvalid_o,
   input wire logic rready_i,
   output logic [31:0] rdata_o,
   output sspc_pkg::sspc_resp_type rresp_o,
   // serial link
   input wire logic link_clk_i,
   input wire logic link_frame_n_i,
   input wire logic link_rx_i,
   output logic serial_transmit_pin_o,
   output logic serial_transmit_pin_oe_n_o,
   // settings for the rest of the port
   output sspc_pkg::sspc_format_type frame_format_select_o,
   output logic [4:0] word_length_o
);
   import sspc_pkg::*;

   // ****************************************
   // register file
   // ****************************************
   logic [15:0] primary_q;
   logic [3:0] secondary_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic [11:0] aw_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   logic bvalid_q;
   logic bresp_err_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic rresp_err_q;

   function automatic logic known_off(input logic [11:0] a);
      known_off = (a == `SSPC_OFF_PRIMARY) || (a == `SSPC_OFF_SECONDARY)
         || (a == `SSPC_OFF_DATA) || (a == `SSPC_OFF_STATUS);
   endfunction

   wire slave_mode = secondary_q[`SSPC_MS_BIT];
   wire port_en = secondary_q[`SSPC_SSE_BIT];
   wire out_dis = secondary_q[`SSPC_SOD_BIT];
   wire loopback = secondary_q[`SSPC_LBM_BIT];
   wire [1:0] fmt_raw = primary_q[`SSPC_FRF_LSB +: 2];
   wire [3:0] size_raw = primary_q[`SSPC_DSS_LSB +: 4];

   assign awready_o = !aw_hold_q && !bvalid_q;
   assign wready_o = !w_hold_q && !bvalid_q;
   wire aw_take = awvalid_i && awready_o;
   wire w_take = wvalid_i && wready_o;
   wire have_aw = aw_hold_q || aw_take;
   wire have_w = w_hold_q || w_take;
   wire [11:0] wr_addr = aw_take ? awaddr_i : aw_q;
   wire [31:0] wr_data = w_take ? wdata_i : wd_q;
   wire [3:0] wr_strb = w_take ? wstrb_i : ws_q;
   wire wr_do = have_aw && have_w && !bvalid_q;
   wire wr_prim = wr_do && (wr_addr == `SSPC_OFF_PRIMARY);
   wire wr_sec = wr_do && (wr_addr == `SSPC_OFF_SECONDARY);
   wire wr_dat = wr_do && (wr_addr == `SSPC_OFF_DATA);
   // control fields change only while the port is disabled
   wire cfg_ok = !port_en;
   wire [15:0] prim_d = {wr_strb[1] ? wr_data[15:8] : primary_q[15:8],
      wr_strb[0] ? wr_data[7:0] : primary_q[7:0]};
   // select and field bits locked while enabled; enable bit always writable
   wire [3:0] sec_d = cfg_ok ? wr_data[3:0]
      : {secondary_q[3:2], wr_data[`SSPC_SSE_BIT], secondary_q[0]};

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         primary_q <= `SSPC_PRIMARY_RST;
         secondary_q <= `SSPC_SECONDARY_RST;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_q <= '0;
         wd_q <= '0;
         ws_q <= '0;
         bvalid_q <= 1'b0;
         bresp_err_q <= 1'b0;
      end
      else
      begin
         if (aw_take && !wr_do)
         begin
            aw_hold_q <= 1'b1;
            aw_q <= awaddr_i;
         end
         if (w_take && !wr_do)
         begin
            w_hold_q <= 1'b1;
            wd_q <= wdata_i;
            ws_q <= wstrb_i;
         end
         if (wr_do)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_err_q <= !known_off(wr_addr);
         end
         else if (bvalid_q && bready_i)
            bvalid_q <= 1'b0;
         if (wr_prim && cfg_ok)
            primary_q <= prim_d;
         if (wr_sec && wr_strb[0])
            secondary_q <= sec_d;
      end
   end
   assign bvalid_o = bvalid_q;
   assign bresp_o = bresp_err_q ? SSPC_RESP_SLVERR : SSPC_RESP_OKAY;

   // ****************************************
   // format decode
   // ****************************************
   // reserved format falls back to spi framing
   assign frame_format_select_o = (fmt_raw == 2'h3) ? SSPC_FMT_SPI
      : sspc_format_type'(fmt_raw);
   // reserved sizes clamp to the shortest legal word
   wire [3:0] size_eff = (size_raw < 4'h3) ? 4'h3 : size_raw;
   wire [4:0] word_len = {1'b0, size_eff} + 5'h01;
   assign word_length_o = word_len;

   // ****************************************
   // link sampling
   // ****************************************
   logic [1:0] sclk_sync_q;
   logic [1:0] fss_sync_q;
   logic [1:0] rx_sync_q;
   logic sclk_prev_q;
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sclk_sync_q <= '0;
         fss_sync_q <= 2'h3;
         rx_sync_q <= '0;
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         sclk_sync_q <= {sclk_sync_q[0], link_clk_i};
         fss_sync_q <= {fss_sync_q[0], link_frame_n_i};
         rx_sync_q <= {rx_sync_q[0], link_rx_i};
         sclk_prev_q <= sclk_sync_q[1];
      end
   end
   wire sclk_rise = sclk_sync_q[1] && !sclk_prev_q;
   wire sclk_fall = !sclk_sync_q[1] && sclk_prev_q;
   wire frame_act = !fss_sync_q[1];

   // ****************************************
   // transmit fifo and slave shifter
   // ****************************************
   logic [15:0] tx_word;
   logic tx_valid;
   logic tx_pop;
   logic tx_full;
   sspc_fifo #(.WIDTH(`SSPC_WORD_W), .DEPTH(`SSPC_FIFO_DEPTH)) u_txf
   (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(wr_dat),
      .in_ready_o(),
      .in_data_i(wr_data[15:0]),
      .out_valid_o(tx_valid),
      .out_ready_i(tx_pop),
      .out_data_o(tx_word),
      .full_o(tx_full),
      .empty_o()
   );

   sspc_state_type st_q;
   sspc_state_type st_d;
   logic [15:0] sh_q;
   logic [4:0] bit_q;
   logic [15:0] rx_q;
   logic [15:0] rx_last_q;
   wire slave_run = port_en && slave_mode;
   wire last_bit = (bit_q == word_len - 5'h01);
   wire [16:0] rx_mask = (17'h1 << word_len) - 17'h1;
   assign tx_pop = (st_q == SSPC_ST_LOAD) && tx_valid;

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         SSPC_ST_IDLE:
            if (slave_run && frame_act)
               st_d = SSPC_ST_LOAD;
         SSPC_ST_LOAD:
            st_d = SSPC_ST_SHIFT;
         SSPC_ST_SHIFT:
            if (!frame_act || !slave_run)
               st_d = SSPC_ST_IDLE;
            else if (sclk_fall && last_bit)
               st_d = SSPC_ST_DONE;
         SSPC_ST_DONE:
            st_d = frame_act ? SSPC_ST_LOAD : SSPC_ST_IDLE;
         default:
            st_d = SSPC_ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_q <= SSPC_ST_IDLE;
         sh_q <= '0;
         bit_q <= '0;
         rx_q <= '0;
         rx_last_q <= '0;
      end
      else
      begin
         st_q <= st_d;
         if (st_q == SSPC_ST_LOAD)
         begin
            sh_q <= tx_valid ? (tx_word << (5'd16 - word_len)) : '0;
            bit_q <= '0;
         end
         else if (st_q == SSPC_ST_SHIFT)
         begin
            if (sclk_rise)
               rx_q <= {rx_q[14:0], loopback ? sh_q[15] : rx_sync_q[1]};
            if (sclk_fall)
            begin
               sh_q <= {sh_q[14:0], 1'b0};
               bit_q <= bit_q + 5'h01;
            end
         end
         if (st_q == SSPC_ST_DONE)
            rx_last_q <= rx_q & rx_mask[15:0];
      end
   end

   // ****************************************
   // transmit pin drive
   // ****************************************
   // master mode with port_en set enables the pin here too, driving sh_q[15]; the pin idles low
   wire drive_en = slave_run && !out_dis && (st_q == SSPC_ST_SHIFT)
      && !loopback;
   logic txd_q;
   logic txoe_n_q;
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         txd_q <= 1'b0;
         txoe_n_q <= 1'b1;
      end
      else
      begin
         txd_q <= sh_q[15];
         txoe_n_q <= !(drive_en || (port_en && !slave_mode));
      end
   end
   assign serial_transmit_pin_o = txd_q;
   assign serial_transmit_pin_oe_n_o = txoe_n_q;

   // ****************************************
   // read channel
   // ****************************************
   wire [31:0] status_w = {27'h0, st_q != SSPC_ST_IDLE, 2'b00, !tx_full, !tx_valid};
   wire [31:0] rd_mux = (araddr_i == `SSPC_OFF_PRIMARY) ? {16'h0, primary_q}
      : (araddr_i == `SSPC_OFF_SECONDARY) ? {28'h0, secondary_q}
      : (araddr_i == `SSPC_OFF_DATA) ? {16'h0, rx_last_q}
      : (araddr_i == `SSPC_OFF_STATUS) ? status_w : 32'h0;
   assign arready_o = !rvalid_q;
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_err_q <= 1'b0;
      end
      else if (arvalid_i && arready_o)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_err_q <= !known_off(araddr_i);
      end
      else if (rvalid_q && rready_i)
         rvalid_q <= 1'b0;
   end
   assign rvalid_o = rvalid_q;
   assign rdata_o = rdata_q;
   assign rresp_o = rresp_err_q ? SSPC_RESP_SLVERR : SSPC_RESP_OKAY;
endmodule
`default_nettype wire

//--- pkg/sspc_consts.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the main design file
`ifndef SSPC_CONSTS_SVH
`define SSPC_CONSTS_SVH
`define SSPC_OFF_PRIMARY 12'h000
`define SSPC_OFF_SECONDARY 12'h004
`define SSPC_OFF_DATA 12'h008
`define SSPC_OFF_STATUS 12'h00c
`define SSPC_FRF_LSB 4
`define SSPC_DSS_LSB 0
`define SSPC_SOD_BIT 3
`define SSPC_MS_BIT 2
`define SSPC_SSE_BIT 1
`define SSPC_LBM_BIT 0
`define SSPC_PRIMARY_RST 16'h0000
`define SSPC_SECONDARY_RST 4'h0
`define SSPC_FIFO_DEPTH 32
`define SSPC_WORD_W 16
`define SSPC_LINK_PERIOD_NS 125
`define SSPC_CLK_PERIOD_NS 10
`endif

//--- pkg/sspc_pkg.sv
// types shared by the serial port control block
// assumes sspc_consts.svh beside it
`default_nettype none
package sspc_pkg;
   typedef enum logic [1:0]
   {
      SSPC_FMT_SPI = 2'h0,
      SSPC_FMT_FRAME_PULSE = 2'h1,
      SSPC_FMT_THREE_WIRE = 2'h2,
      SSPC_FMT_RESERVED = 2'h3
   } sspc_format_type;
   typedef enum logic [3:0]
   {
      SSPC_ST_IDLE = 4'h1,
      SSPC_ST_LOAD = 4'h2,
      SSPC_ST_SHIFT = 4'h4,
      SSPC_ST_DONE = 4'h8
   } sspc_state_type;
   typedef logic [1:0] sspc_resp_type;
   localparam sspc_resp_type SSPC_RESP_OKAY = 2'h0;
   localparam sspc_resp_type SSPC_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- hw/sspc_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module sspc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   // fill state
   output logic full_o,
   output logic empty_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign full_o = (cnt_q == (AW+1)'(DEPTH));
   assign empty_o = (cnt_q == '0);
   assign in_ready_o = !full_o;
   assign out_valid_o = !empty_o;
   assign out_data_o = mem_q[rd_q];
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
   always_ff @(posedge core_clk_i)
   begin
      if (push)
         mem_q[wr_q] <= in_data_i;
   end
endmodule
`default_nettype wire

//--- tb/sspc_top_properties.sv
// checker for bus answers, decoded settings and transmit drive
// assumes bind to sspc_top; aw and w offered together
`timescale 1ns/1ps
`default_nettype none
module sspc_top_properties
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // bus
   input wire logic awvalid_i,
   input wire logic awready_o,
   input wire logic [11:0] awaddr_i,
   input wire logic wvalid_i,
   input wire logic wready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic bvalid_o,
   input wire logic arvalid_i,
   input wire logic arready_o,
   input wire logic rvalid_o,
   // settings and pin
   input wire logic serial_transmit_pin_oe_n_o,
   input wire sspc_pkg::sspc_format_type frame_format_select_o,
   input wire logic [4:0] word_length_o
);
   import sspc_pkg::*;
   // ****************
   // shadow settings
   // ****************
   logic [3:0] sec_q;
   logic [4:0] len_q;
   logic [1:0] fmt_q;
   logic wr_hs;
   logic prim_hs;
   logic sod_on;
   logic mst_on;
   assign wr_hs = awvalid_i && awready_o && wvalid_i && wready_o && wstrb_i[0];
   assign prim_hs = wr_hs && awaddr_i == 12'h000 && !sec_q[1];
   assign sod_on = sec_q[3:2] == 2'h3;
   assign mst_on = sec_q[2:0] == 3'h2;
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sec_q <= 4'h0;
         len_q <= 5'h04;
         fmt_q <= 2'h0;
      end
      else if (wr_hs && awaddr_i == 12'h004)
         sec_q <= sec_q[1] ? {sec_q[3:2], wdata_i[1], sec_q[0]} : wdata_i[3:0];
      else if (prim_hs)
      begin
         len_q <= (wdata_i[3:0] < 4'h3) ? 5'h04 : {1'b0, wdata_i[3:0]} + 5'h01;
         fmt_q <= (wdata_i[5:4] == 2'h3) ? 2'h0 : wdata_i[5:4];
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence wr_take;
      awvalid_i && awready_o && wvalid_i && wready_o;
   endsequence
   chk_fmt_follow: assert property (prim_hs |-> ##2 frame_format_select_o == fmt_q)
      else $error("format output wrong after write");
   chk_fmt_legal: assert property (frame_format_select_o != SSPC_FMT_RESERVED)
      else $error("reserved format on output");
   chk_len_follow: assert property (prim_hs |-> ##2 word_length_o == len_q)
      else $error("word length wrong after write");
   chk_len_range: assert property (word_length_o >= 5'h04 && word_length_o <= 5'h10)
      else $error("word length out of range");
   chk_sod_quiet: assert property (sod_on && $past(sod_on) && $past(sod_on, 2)
      |-> serial_transmit_pin_oe_n_o)
      else $error("slave drives pin with output disabled");
   chk_master_drive: assert property (mst_on && $past(mst_on) && $past(mst_on, 2)
      |-> !serial_transmit_pin_oe_n_o)
      else $error("enabled master does not drive pin");
   chk_wr_answer: assert property (wr_take |=> bvalid_o)
      else $error("write response late");
   chk_rd_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
      else $error("read response late");
   chk_ar_block: assert property (rvalid_o |-> !arready_o)
      else $error("read address taken while answer pending");
endmodule
bind sspc_top sspc_top_properties sspc_top_properties_i (.core_clk_i, .nrst_i, .awvalid_i,
   .awready_o, .awaddr_i, .wvalid_i, .wready_o, .wdata_i, .wstrb_i, .bvalid_o, .arvalid_i,
   .arready_o, .rvalid_o, .serial_transmit_pin_oe_n_o, .frame_format_select_o,
   .word_length_o);
`default_nettype wire

//--- tb/sspc_link_master.sv
// serial master model: link clock, frame select, receive data
// assumes clock idle low between frames, 125 ns period
`timescale 1ns/1ps
`default_nettype none
module sspc_link_master
(
   // link outputs
   output var logic clk_o,
   output var logic frame_n_o,
   output var logic rx_o,
   // device pin
   input wire logic tx_i,
   input wire logic oe_n_i
);
   initial
   begin
      clk_o = 1'b0;
      frame_n_o = 1'b1;
      rx_o = 1'b1;
   end
   // one frame, msb first; counts samples with the pin driven
   task automatic xfer(input int n, input logic [15:0] d, output logic [15:0] q, output int drv);
      q = 16'h0000;
      drv = 0;
      #1;
      frame_n_o = 1'b0;
      #62.5;
      for (int i = n - 1; i >= 0; i--)
      begin
         rx_o = d[i];
         #62.5;
         clk_o = 1'b1;
         q = {q[14:0], tx_i};
         drv = drv + (oe_n_i === 1'b0);
         #62.5;
         clk_o = 1'b0;
      end
      #62.5;
      frame_n_o = 1'b1;
      rx_o = ~rx_o;
   endtask
endmodule
`default_nettype wire

//--- tb/sspc_top_tb.sv
// self-checking bench for sspc_top
// assumes sspc_link_master on the link and the bound checker
`timescale 1ns/1ps
`default_nettype none
module sspc_top_tb;
   import sspc_pkg::*;
   logic core_clk_i, nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
   logic [11:0] awaddr_i, araddr_i;
   logic [31:0] wdata_i, rdata_o, rdat;
   logic [3:0] wstrb_i;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
   logic serial_transmit_pin_o, serial_transmit_pin_oe_n_o;
   wire link_clk_i, link_frame_n_i, link_rx_i;
   sspc_resp_type bresp_o, rresp_o, rr;
   sspc_format_type frame_format_select_o;
   logic [4:0] word_length_o;
   logic [15:0] q;
   int n_fail = 0, tests_run = 0, cyc = 0, drv;
   sspc_top sspc_top_i (.core_clk_i, .nrst_i, .awvalid_i, .awready_o, .awaddr_i, .wvalid_i,
      .wready_o, .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o,
      .araddr_i, .rvalid_o, .rready_i, .rdata_o, .rresp_o, .link_clk_i, .link_frame_n_i,
      .link_rx_i, .serial_transmit_pin_o, .serial_transmit_pin_oe_n_o, .frame_format_select_o,
      .word_length_o);
   sspc_link_master sspc_link_master_i (.clk_o(link_clk_i), .frame_n_o(link_frame_n_i),
      .rx_o(link_rx_i), .tx_i(serial_transmit_pin_o), .oe_n_i(serial_transmit_pin_oe_n_o));
   // ****************
   // shared tasks
   // ****************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      {awaddr_i, wdata_i} <= {a, d};
      {awvalid_i, wvalid_i, bready_i} <= 3'h7;
      do
      begin
         @(posedge core_clk_i);
         awvalid_i <= awvalid_i && !awready_o;
         wvalid_i <= wvalid_i && !wready_o;
      end
      while (!bvalid_o);
      bready_i <= 1'b0;
      rr = bresp_o;
   endtask
   task automatic rd_reg(input logic [11:0] a);
      @(posedge core_clk_i);
      araddr_i <= a;
      {arvalid_i, rready_i} <= 2'h3;
      do
      begin
         @(posedge core_clk_i);
         arvalid_i <= arvalid_i && !arready_o;
      end
      while (!rvalid_o);
      rready_i <= 1'b0;
      {rdat, rr} = {rdata_o, rresp_o};
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_reset;
      check(serial_transmit_pin_oe_n_o, 1'b1);
      check(frame_format_select_o, SSPC_FMT_SPI);
      check(word_length_o, 5'h04);
      rd_reg(12'h000);
      check(rdat, 32'h0);
      rd_reg(12'h004);
      check(rdat, 32'h0);
      rd_reg(12'h008);
      check(rdat, 32'h0);
      rd_reg(12'h00c);
      check(rdat, 32'h3);
      rd_reg(12'h010);
      check({rdat[29:0], rr}, {30'h0, SSPC_RESP_SLVERR});
      wr(12'h010, 32'h1);
      check(rr, SSPC_RESP_SLVERR);
      $display("reset test done");
   endtask
   task automatic t_fields;
      for (int i = 0; i < 16; i++)
      begin
         wr(12'h000, (i % 4) * 16 + i);
         rd_reg(12'h000);
         check(rdat, (i % 4) * 16 + i);
         check(frame_format_select_o, (i % 4 == 3) ? 0 : i % 4);
         check(word_length_o, (i < 3) ? 4 : i + 1);
      end
      $display("field test done");
   endtask
   task automatic t_lock;
      wr(12'h000, 32'h07);
      wr(12'h004, 32'h4);
      wr(12'h004, 32'h6);
      wr(12'h000, 32'h13);
      rd_reg(12'h000);
      check(rdat, 32'h07);
      check(word_length_o, 5'h08);
      wr(12'h004, 32'h2);
      rd_reg(12'h004);
      check(rdat, 32'h6);
      $display("lock test done");
   endtask
   task automatic t_slave;
      wr(12'h008, 32'ha5);
      sspc_link_master_i.xfer(8, 16'h3c, q, drv);
      check(q, 16'ha5);
      check(drv, 8);
      repeat (6) @(posedge core_clk_i);
      rd_reg(12'h008);
      check(rdat, 32'h3c);
      $display("slave test done");
   endtask
   task automatic t_sod;
      wr(12'h004, 32'h0);
      wr(12'h004, 32'hc);
      wr(12'h004, 32'he);
      wr(12'h008, 32'h5a);
      sspc_link_master_i.xfer(8, 16'hc3, q, drv);
      check(drv, 0);
      check(serial_transmit_pin_oe_n_o, 1'b1);
      $display("output disable test done");
   endtask
   task automatic t_master;
      wr(12'h004, 32'h0);
      wr(12'h004, 32'h8);
      wr(12'h004, 32'ha);
      repeat (4) @(posedge core_clk_i);
      check(serial_transmit_pin_oe_n_o, 1'b0);
      $display("master test done");
   endtask
   task automatic t_loop;
      wr(12'h004, 32'h0);
      wr(12'h004, 32'h5);
      wr(12'h004, 32'h7);
      wr(12'h008, 32'h96);
      sspc_link_master_i.xfer(8, 16'h00, q, drv);
      check(drv, 0);
      repeat (6) @(posedge core_clk_i);
      rd_reg(12'h008);
      check(rdat, 32'h96);
      $display("loopback test done");
   endtask
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         wrap_up;
      end
   end
   initial
   begin
      {nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 6'h0;
      {awaddr_i, araddr_i, wdata_i} = 56'h0;
      wstrb_i = 4'hf;
      repeat (20) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      t_reset;
      t_fields;
      t_lock;
      t_slave;
      t_sod;
      t_master;
      t_loop;
      @(posedge core_clk_i);
      nrst_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      t_reset;
      wrap_up;
   end
endmodule
`default_nettype wire
